// ---- src/adcs_map.svh ----
// word widths, timing figures and command codes of the converter serial block
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH

// =========================================
// timing
`define ADCS_MCLK_HZ 20000000
`define ADCS_DATA_RATE_SPS 1000
`define ADCS_LAT_WHOLE_PERIODS 62
`define ADCS_LAT_FRAC_NUM 251
`define ADCS_LAT_FRAC_DEN 256
`define ADCS_SYNC_LAT_CLKS 466
`define ADCS_RESET_LAT_CLKS 468
`define ADCS_IDLE_READY_EDGES 64
`define ADCS_READY_LOW_CLKS 4
`define ADCS_FALL_GUARD_CLKS 3

// =========================================
// command codes
`define ADCS_CMD_READ_ONCE 8'h12
`define ADCS_CMD_CONT_START 8'h10
`define ADCS_CMD_CONT_STOP 8'h11

// =========================================
// word layout
`define ADCS_WORD_W 32
`define ADCS_CMD_W 8

`endif

// ---- src/adcs_pkg.sv ----
// types of the converter serial block
`include "adcs_map.svh"

package adcs_pkg;

    // =========================================
    // serial pins seen by the device
    typedef struct packed {
        logic serialClk;
        logic serialDataIn;
    } adcs_ser_in_t;

    // =========================================
    // received command byte
    typedef struct packed {
        logic strobe;
        logic [`ADCS_CMD_W-1:0] code;
    } adcs_cmd_t;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_SETTLE,
        ST_RUN
    } adcs_state_t;

endpackage

// ---- src/adcs_serial_core.sv ----
// serial port, sync/reset qualification and data-ready timing
`timescale 1ns/10ps
`include "adcs_map.svh"

// Behaviour
// - serial clock low over 64 data-ready falls returns interface to idle.
// - serial input sampled on serial clock rising edges.
// - serial output advances after each serial clock falling edge.
// - in continuous read, or with a read-data command pending, word MSB appears on serial output as data-ready falls.
// - sync acts three master clock edges after the edge that first samples it high, once held two samples.
// - continuous-sync mode ignores sync edges aligned to the data period.
// - after sync, first data-ready after 62.98046875 periods plus 466 clocks.
// - reset pin sampled only on master clock edges.
// - after reset, first data-ready after 62.98046875 periods plus 468 clocks.
// - read-data command gets a new word within one data period.
module adcs_serial_core #(
    parameter int DATA_PERIOD = `ADCS_MCLK_HZ / `ADCS_DATA_RATE_SPS,
    parameter int SYNC_LAT = DATA_PERIOD * `ADCS_LAT_WHOLE_PERIODS
        + (DATA_PERIOD * `ADCS_LAT_FRAC_NUM) / `ADCS_LAT_FRAC_DEN + `ADCS_SYNC_LAT_CLKS,
    parameter int RESET_LAT = DATA_PERIOD * `ADCS_LAT_WHOLE_PERIODS
        + (DATA_PERIOD * `ADCS_LAT_FRAC_NUM) / `ADCS_LAT_FRAC_DEN + `ADCS_RESET_LAT_CLKS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pins from host
    input wire adcs_pkg::adcs_ser_in_t serIn,
    input wire logic syncPin,
    input wire logic resetPinN,
    // configuration level
    input wire logic syncContinuous,
    // conversion word from filter
    input wire logic [`ADCS_WORD_W-1:0] convWord,
    // pins to host
    output logic conversionReadyN,
    output logic serialDataOut,
    // received commands
    output adcs_pkg::adcs_cmd_t cmdOut
);
    import adcs_pkg::*;

    localparam int CW = 32;

    // =========================================
    // pin qualification, three stages each
    logic [2:0] clkSync_r, dinSync_r, syncSync_r, rstSync_r;
    logic clkLvl_r, syncLvl_r, rstLvl_r;
    logic clkRise, clkFall, syncRise, rstRise;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            clkSync_r <= 3'h0;
            dinSync_r <= 3'h0;
            syncSync_r <= 3'h0;
            rstSync_r <= 3'h7;
        end
        else
        begin
            clkSync_r <= {clkSync_r[1:0], serIn.serialClk};
            dinSync_r <= {dinSync_r[1:0], serIn.serialDataIn};
            syncSync_r <= {syncSync_r[1:0], syncPin};
            rstSync_r <= {rstSync_r[1:0], resetPinN};
        end
    end

    assign clkRise = (clkSync_r[2] == clkSync_r[1]) && clkSync_r[2] && !clkLvl_r;
    assign clkFall = (clkSync_r[2] == clkSync_r[1]) && !clkSync_r[2] && clkLvl_r;
    // two agreeing stages need the level held two clocks
    assign syncRise = (syncSync_r[2] == syncSync_r[1]) && syncSync_r[2] && !syncLvl_r;
    assign rstRise = (rstSync_r[2] == rstSync_r[1]) && rstSync_r[2] && !rstLvl_r;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            clkLvl_r <= 1'b0;
            syncLvl_r <= 1'b0;
            rstLvl_r <= 1'b1;
        end
        else
        begin
            if (clkSync_r[2] == clkSync_r[1])
                clkLvl_r <= clkSync_r[2];
            if (syncSync_r[2] == syncSync_r[1])
                syncLvl_r <= syncSync_r[2];
            if (rstSync_r[2] == rstSync_r[1])
                rstLvl_r <= rstSync_r[2];
        end
    end

    // =========================================
    // conversion timing
    adcs_state_t state_r;
    logic [CW-1:0] latCnt_r, periodCnt_r, syncPhase_r;
    logic phaseValid_r, readyTick, resync;

    // continuous mode keeps phase if edges stay on the data grid
    assign resync = syncRise && (state_r != ST_HOLD)
        && (!syncContinuous || (state_r == ST_RUN && phaseValid_r
        && periodCnt_r != syncPhase_r));
    assign readyTick = (state_r == ST_SETTLE && latCnt_r == '0)
        || (state_r == ST_RUN && periodCnt_r == CW'(DATA_PERIOD - 1));

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            state_r <= ST_SETTLE;
            latCnt_r <= CW'(RESET_LAT - 1);
            periodCnt_r <= '0;
        end
        else if (state_r == ST_HOLD && rstRise)
        begin
            // rise is seen while the level flop is still low
            state_r <= ST_SETTLE;
            latCnt_r <= CW'(RESET_LAT - 1);
        end
        else if (!rstLvl_r)
        begin
            state_r <= ST_HOLD;
            periodCnt_r <= '0;
        end
        else if (resync)
        begin
            state_r <= ST_SETTLE;
            latCnt_r <= CW'(SYNC_LAT - 1);
        end
        else if (state_r == ST_SETTLE)
        begin
            latCnt_r <= latCnt_r - CW'(1);
            if (latCnt_r == '0)
            begin
                state_r <= ST_RUN;
                periodCnt_r <= '0;
            end
        end
        else if (state_r == ST_RUN)
        begin
            periodCnt_r <= readyTick ? '0 : periodCnt_r + CW'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset || !rstLvl_r || resync || state_r != ST_RUN)
        begin
            phaseValid_r <= 1'b0;
            syncPhase_r <= '0;
        end
        else if (syncRise && !phaseValid_r)
        begin
            phaseValid_r <= 1'b1;
            syncPhase_r <= periodCnt_r;
        end
    end

    // =========================================
    // data-ready pulse, low once per period
    logic [3:0] lowCnt_r;

    always_ff @(posedge core_clk)
    begin
        if (reset || !rstLvl_r || resync)
        begin
            conversionReadyN <= 1'b1;
            lowCnt_r <= '0;
        end
        else if (readyTick)
        begin
            conversionReadyN <= 1'b0;
            lowCnt_r <= 4'(`ADCS_READY_LOW_CLKS - 1);
        end
        else if (lowCnt_r != '0)
            lowCnt_r <= lowCnt_r - 4'h1;
        else
            conversionReadyN <= 1'b1;
    end

    // =========================================
    // idle detect: clock low across many data-ready falls
    logic [6:0] idleCnt_r;
    logic idleHit;

    assign idleHit = readyTick && !clkLvl_r && idleCnt_r == 7'(`ADCS_IDLE_READY_EDGES - 1);

    always_ff @(posedge core_clk)
    begin
        if (reset || clkLvl_r || clkRise || idleHit)
            idleCnt_r <= '0;
        else if (readyTick)
            idleCnt_r <= idleCnt_r + 7'h1;
    end

    // =========================================
    // command receive
    logic [`ADCS_CMD_W-1:0] cmdShift_r;
    logic [2:0] bitCnt_r;
    logic cmdDone;
    logic [`ADCS_CMD_W-1:0] cmdCode;

    assign cmdCode = {cmdShift_r[`ADCS_CMD_W-2:0], dinSync_r[2]};
    assign cmdDone = clkRise && bitCnt_r == 3'h7;

    always_ff @(posedge core_clk)
    begin
        if (reset || !rstLvl_r || idleHit)
        begin
            cmdShift_r <= '0;
            bitCnt_r <= '0;
        end
        else if (clkRise)
        begin
            cmdShift_r <= cmdCode;
            bitCnt_r <= bitCnt_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            cmdOut <= '0;
        else
        begin
            cmdOut.strobe <= cmdDone;
            if (cmdDone)
                cmdOut.code <= cmdCode;
        end
    end

    // =========================================
    // read modes and word output
    logic contRead_r, readPending_r;
    logic [`ADCS_WORD_W-1:0] outShift_r;
    logic [1:0] fallGuard_r;

    always_ff @(posedge core_clk)
    begin
        if (reset || !rstLvl_r)
        begin
            contRead_r <= 1'b1;
            readPending_r <= 1'b0;
        end
        else
        begin
            if (cmdDone && cmdCode == `ADCS_CMD_CONT_START)
                contRead_r <= 1'b1;
            else if (cmdDone && cmdCode == `ADCS_CMD_CONT_STOP)
                contRead_r <= 1'b0;
            // a command in the load cycle still waits for the next word
            if (cmdDone && cmdCode == `ADCS_CMD_READ_ONCE)
                readPending_r <= 1'b1;
            else if (readyTick)
                readPending_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            outShift_r <= '0;
            serialDataOut <= 1'b0;
            fallGuard_r <= 2'h0;
        end
        else if (readyTick && (contRead_r || readPending_r))
        begin
            outShift_r <= convWord;
            serialDataOut <= convWord[`ADCS_WORD_W-1];
            // falls still in the pin chain came before the load
            fallGuard_r <= 2'(`ADCS_FALL_GUARD_CLKS);
        end
        else if (clkFall && fallGuard_r == 2'h0)
        begin
            outShift_r <= {outShift_r[`ADCS_WORD_W-2:0], 1'b0};
            serialDataOut <= outShift_r[`ADCS_WORD_W-2];
        end
        else if (fallGuard_r != 2'h0)
            fallGuard_r <= fallGuard_r - 2'h1;
    end

endmodule

// ---- dv/adcs_serial_core_assertions.sv ----
// port checks of the converter serial block
`timescale 1ns/10ps
`include "adcs_map.svh"
module adcs_serial_core_assertions #(parameter int DATA_PERIOD = 32) (
    // inputs
    input wire logic core_clk,
    input wire logic reset,
    input wire adcs_pkg::adcs_ser_in_t serIn,
    input wire logic syncPin,
    input wire logic resetPinN,
    input wire logic syncContinuous,
    input wire logic [`ADCS_WORD_W-1:0] convWord,
    // outputs
    input wire logic conversionReadyN,
    input wire logic serialDataOut,
    input wire adcs_pkg::adcs_cmd_t cmdOut
);
    import adcs_pkg::*;
    logic [15:0] gap_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // cycles since the last data-ready fall
    always_ff @(posedge core_clk)
    begin
        if (reset || $fell(conversionReadyN))
            gap_r <= 16'h0001;
        else if (gap_r != 16'hffff)
            gap_r <= gap_r + 16'h0001;
    end
    sequence s_lowTail;
        !conversionReadyN [*3] ##1 conversionReadyN;
    endsequence
    property p_lowWidth;
        $fell(conversionReadyN) |-> ##1 s_lowTail;
    endproperty
    a_lowWidth: assert property (p_lowWidth) else $error("ready low width");
    property p_cadence;
        $fell(conversionReadyN) |-> gap_r >= DATA_PERIOD;
    endproperty
    a_cadence: assert property (p_cadence) else $error("ready too early");
    property p_resetHold;
        !resetPinN [*8] |-> conversionReadyN;
    endproperty
    a_resetHold: assert property (p_resetHold) else $error("ready in pin reset");
    property p_sdoStep;
        $changed(serialDataOut) |-> $fell(conversionReadyN) || !$past(serIn.serialClk, 3);
    endproperty
    a_sdoStep: assert property (p_sdoStep) else $error("data out moved early");
    property p_strobeOne;
        cmdOut.strobe |=> !cmdOut.strobe [*8];
    endproperty
    a_strobeOne: assert property (p_strobeOne) else $error("strobe too long");
    property p_strobeRise;
        cmdOut.strobe |-> $past(serIn.serialClk, 2);
    endproperty
    a_strobeRise: assert property (p_strobeRise) else $error("strobe without rise");
    property p_syncDrop;
        $rose(syncPin) && !syncContinuous |-> ##5 conversionReadyN [*8];
    endproperty
    a_syncDrop: assert property (p_syncDrop) else $error("ready after sync");
    property p_resetQuiet;
        $rose(resetPinN) |-> conversionReadyN [*8];
    endproperty
    a_resetQuiet: assert property (p_resetQuiet) else $error("ready after pin reset");
endmodule

bind adcs_serial_core adcs_serial_core_assertions #(.DATA_PERIOD(DATA_PERIOD)) u_chk (.*);

// ---- dv/adcs_host_model.sv ----
// host model driving the serial, sync and reset pins of the block
`timescale 1ns/10ps
module adcs_host_model (
    // clock
    input wire logic core_clk,
    // device pins
    output adcs_pkg::adcs_ser_in_t serIn,
    output logic syncPin,
    output logic resetPinN,
    input wire logic serialDataOut
);
    import adcs_pkg::*;
    initial
    begin
        serIn = '0;
        syncPin = 1'b0;
        resetPinN = 1'b1;
    end
    task automatic clk(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // one bit: 8 clocks low, 8 high; device bit taken before the rise
    task automatic bitXfer(input logic d, output logic q);
        serIn.serialDataIn <= d;
        clk(4);
        q = serialDataOut;
        serIn.serialClk <= 1'b1;
        clk(8);
        serIn.serialClk <= 1'b0;
        clk(4);
    endtask
    task automatic sendByte(input logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--)
            bitXfer(b[i], q);
        serIn.serialDataIn <= ~b[0];
        clk(24);
    endtask
    task automatic readWord(output logic [31:0] w);
        for (int i = 31; i >= 0; i--)
            bitXfer(1'b0, w[i]);
    endtask
    task automatic pulseSync();
        syncPin <= 1'b1;
        clk(4);
        syncPin <= 1'b0;
    endtask
    task automatic pulseReset();
        resetPinN <= 1'b0;
        clk(8);
        resetPinN <= 1'b1;
    endtask
endmodule

// ---- dv/adcs_serial_core_test.sv ----
// self-checking bench for the converter serial block
`timescale 1ns/10ps
`include "adcs_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module adcs_serial_core_test;
    import adcs_pkg::*;
    localparam int P = 32;
    localparam int SL = 62 * P + P * 251 / 256 + 466;
    localparam int RL = 62 * P + P * 251 / 256 + 468;
    localparam logic [31:0] W1 = 32'h9a3c_5e71;
    localparam logic [31:0] W2 = 32'h63c5_a18e;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic syncContinuous = 1'b0;
    logic [31:0] convWord = W1;
    adcs_ser_in_t serIn;
    logic syncPin, resetPinN, conversionReadyN, serialDataOut;
    adcs_cmd_t cmdOut;
    int err_count = 0;
    int cmp_count = 0;
    int n;
    logic [31:0] rd;
    // command byte sent, code expected back
    logic [15:0] rows [4] = '{16'h1010, 16'h1212, 16'ha5a5, 16'h1111};
    always #25 core_clk = ~core_clk;
    adcs_serial_core #(.DATA_PERIOD(P)) dut (.*);
    adcs_host_model host (.*);
    task automatic clk(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    // edges until a sampled high-to-low step of data-ready
    task automatic waitFall(output int k);
        logic prev;
        k = 0;
        prev = 1'b0;
        while (!(prev && conversionReadyN === 1'b0) && k < 6000)
        begin
            prev = (conversionReadyN === 1'b1);
            @(posedge core_clk);
            k++;
        end
    endtask
    task automatic summarize();
        $display("errors %0d of %0d checks", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clk(40000);
        err_count++;
        summarize();
    end
    initial
    begin
        clk(12);
        reset <= 1'b0;
        waitFall(n);
        `CHK("rst lat", 1'b1, n >= RL && n <= RL + 2)
        `CHK("msb", W1[31], serialDataOut)
        convWord <= W2;
        waitFall(n);
        `CHK("period", P, n)
        `CHK("msb", W2[31], serialDataOut)
        foreach (rows[i])
        begin
            host.sendByte(rows[i][15:8]);
            `CHK("cmd", rows[i][7:0], cmdOut.code)
        end
        convWord <= W1;
        host.sendByte(`ADCS_CMD_READ_ONCE);
        clk(P);
        host.readWord(rd);
        `CHK("word", W1, rd)
        for (int i = 0; i < 3; i++)
            host.bitXfer(1'b1, rd[i]);
        clk(64 * P + 4);
        host.sendByte(8'h3c);
        `CHK("idle", 8'h3c, cmdOut.code)
        waitFall(n);
        clk(8);
        host.pulseSync();
        waitFall(n);
        `CHK("sync lat", 1'b1, n >= SL - 2 && n <= SL + 2)
        syncContinuous <= 1'b1;
        waitFall(n);
        clk(8);
        host.pulseSync();
        clk(P - 4);
        host.pulseSync();
        waitFall(n);
        `CHK("cont sync", 1'b1, n <= P)
        clk(20);
        host.pulseSync();
        waitFall(n);
        `CHK("off-grid sync", 1'b1, n >= SL - 2 && n <= SL + 2)
        clk(8);
        host.pulseReset();
        waitFall(n);
        `CHK("pin rst lat", 1'b1, n >= RL + 1 && n <= RL + 6)
        summarize();
    end
endmodule
